// [include/pin_mux_map.svh]
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH
// Register indices on the plain register port
`define PORT_B_CFG_ADDR 4'h0
`define PORT_C_CFG_ADDR 4'h1
`define PORT_B_OUT_ADDR 4'h2
`define PORT_C_OUT_ADDR 4'h3
`define PORT_B_OE_ADDR 4'h4
`define PORT_C_OE_ADDR 4'h5
`define PORT_B_PIN_ADDR 4'h6
`define PORT_C_PIN_ADDR 4'h7
`define TIMER_CTRL_ADDR 4'h8
`define IRQ_STAT_ADDR 4'h9
`define IRQ_MASK_ADDR 4'ha
// Timer control field positions
`define TCTL_T0_SEL_BIT 0
`define TCTL_T1_SEL_BIT 1
`define TCTL_T2_SEL_BIT 2
`define TCTL_IT0_BIT 3
`define TCTL_IT1_BIT 4
// Interrupt status field positions
`define IRQ_FOUR_BIT 0
`define IRQ_FIVE_BIT 1
`define IRQ_SIX_BIT 2
`define IRQ_ZERO_BIT 3
`define IRQ_ONE_BIT 4
// Select bits of the pins that become alternate inputs
`define B_ALT_IN_MASK 8'h77
`define C_ALT_IN_MASK 6'h3d
// Reset values
`define CFG_B_RESET 8'h00
`define CFG_C_RESET 6'h00
`define TCTL_RESET 5'h00
`define IRQ_RESET 5'h00
`endif

// [include/pin_mux_pkg.sv]
package pin_mux_pkg;
  typedef logic [3:0] reg_addr_type;
  typedef logic [7:0] reg_data_type;
  typedef logic [4:0] irq_vec_type;
endpackage

// [design/port_b_c_alternate_function_mux.sv]
`timescale 1ns/1ps
`include "pin_mux_map.svh"
// Notes on behaviour
// - port_b_line_0 select picks GPIO or timer2 input
// - Timer2 counts pin only when counter-select set
// - port_b_line_1 select picks GPIO or capture/reload
// - port_b_line_2 select feeds uart1 receive
// - port_b_line_3 select drives uart1 transmit output
// - port_b_line_4 rising edge raises irq four
// - port_b_line_5 falling edge raises irq five
// - port_b_line_6 rising edge raises irq six
// - port_b_line_7 select drives timer2 overflow strobe
// - Overflow strobe high one cycle per overflow
// - port_c_line_0 select feeds uart0 receive
// - port_c_line_1 select drives uart0 transmit output
// - port_c_line_2 irq zero, edge or level
// - port_c_line_3 irq one, edge or level
// - port_c_line_4 counts timer0 when counter-select set
// - port_c_line_5 counts timer1 when counter-select set
module port_b_c_alternate_function_mux (
  input wire logic clk_sys_i, // 100 MHz core clock
  input wire logic rst_b_i, // Async reset, active low
  input wire pin_mux_pkg::reg_addr_type reg_addr_i, // Register index
  input wire pin_mux_pkg::reg_data_type reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output pin_mux_pkg::reg_data_type reg_rdata_o, // Read data, cycle after strobe
  input wire logic [7:0] port_b_in_i, // Port B pad inputs
  output logic [7:0] port_b_out_o, // Port B pad outputs
  output logic [7:0] port_b_oe_o, // Port B pad output enables
  input wire logic [5:0] port_c_in_i, // Port C pad inputs
  output logic [5:0] port_c_out_o, // Port C pad outputs
  output logic [5:0] port_c_oe_o, // Port C pad output enables
  input wire logic timer2_overflow_i, // Timer2 overflow event, one cycle
  input wire logic uart1_transmit_i, // UART1 shift clock or data
  input wire logic uart0_transmit_i, // UART0 shift clock or data
  output logic timer0_ext_input_o, // Gated count input timer0
  output logic timer1_ext_input_o, // Gated count input timer1
  output logic timer2_ext_input_o, // Gated count input timer2
  output logic timer2_capture_reload_input_o, // Capture/reload input
  output logic uart1_receive_input_o, // UART1 receive data
  output logic uart0_receive_input_o, // UART0 receive data
  output logic timer0_counter_select_o, // Timer0 counter mode
  output logic timer1_counter_select_o, // Timer1 counter mode
  output logic timer2_counter_select_o, // Timer2 counter mode
  output logic irq_o // Level interrupt, unmasked pending
);
  import pin_mux_pkg::*;

  logic [7:0] port_b_function_config_ff;
  logic [5:0] port_c_function_config_ff;
  logic [7:0] gpio_b_out_ff;
  logic [7:0] gpio_b_oe_ff;
  logic [5:0] gpio_c_out_ff;
  logic [5:0] gpio_c_oe_ff;
  logic [4:0] timer_ctrl_ff;
  irq_vec_type irq_stat_ff;
  irq_vec_type irq_mask_ff;
  irq_vec_type irq_event;
  logic [7:0] port_b_prev_ff;
  logic [5:0] port_c_prev_ff;
  logic timer2_overflow_strobe_ff;
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_rdata;
  logic irq_zero_trigger_type;
  logic irq_one_trigger_type;
  logic stat_rd;

  assign irq_zero_trigger_type = timer_ctrl_ff[`TCTL_IT0_BIT];
  assign irq_one_trigger_type = timer_ctrl_ff[`TCTL_IT1_BIT];
  assign timer0_counter_select_o = timer_ctrl_ff[`TCTL_T0_SEL_BIT];
  assign timer1_counter_select_o = timer_ctrl_ff[`TCTL_T1_SEL_BIT];
  assign timer2_counter_select_o = timer_ctrl_ff[`TCTL_T2_SEL_BIT];
  assign stat_rd = reg_rd_i && (reg_addr_i == `IRQ_STAT_ADDR);

  // Function select registers; zero at reset leaves every pin a GPIO input
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_b_function_config_ff <= `CFG_B_RESET;
      port_c_function_config_ff <= `CFG_C_RESET;
    end else if (reg_wr_i && reg_addr_i == `PORT_B_CFG_ADDR) begin
      port_b_function_config_ff <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == `PORT_C_CFG_ADDR) begin
      port_c_function_config_ff <= reg_wdata_i[5:0];
    end
  end

  // General-purpose output data and direction
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gpio_b_out_ff <= 8'h00;
      gpio_b_oe_ff <= 8'h00;
      gpio_c_out_ff <= 6'h00;
      gpio_c_oe_ff <= 6'h00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PORT_B_OUT_ADDR: gpio_b_out_ff <= reg_wdata_i;
        `PORT_B_OE_ADDR: gpio_b_oe_ff <= reg_wdata_i;
        `PORT_C_OUT_ADDR: gpio_c_out_ff <= reg_wdata_i[5:0];
        `PORT_C_OE_ADDR: gpio_c_oe_ff <= reg_wdata_i[5:0];
        default: ;
      endcase
    end
  end

  // Timer mode and interrupt trigger-type bits
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_ctrl_ff <= `TCTL_RESET;
    end else if (reg_wr_i && reg_addr_i == `TIMER_CTRL_ADDR) begin
      timer_ctrl_ff <= reg_wdata_i[4:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_mask_ff <= `IRQ_RESET;
    end else if (reg_wr_i && reg_addr_i == `IRQ_MASK_ADDR) begin
      irq_mask_ff <= reg_wdata_i[4:0];
    end
  end

  // Previous pin levels for edge detection; pins are synchronous already
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_b_prev_ff <= 8'h00;
      port_c_prev_ff <= 6'h3f; // Active-low lines idle high
    end else begin
      port_b_prev_ff <= port_b_in_i;
      port_c_prev_ff <= port_c_in_i;
    end
  end

  // Interrupt events, only while the pin is given to its interrupt
  always_comb begin
    irq_event = '0;
    irq_event[`IRQ_FOUR_BIT] = port_b_function_config_ff[4] &&
      port_b_in_i[4] && !port_b_prev_ff[4];
    irq_event[`IRQ_FIVE_BIT] = port_b_function_config_ff[5] &&
      !port_b_in_i[5] && port_b_prev_ff[5];
    irq_event[`IRQ_SIX_BIT] = port_b_function_config_ff[6] &&
      port_b_in_i[6] && !port_b_prev_ff[6];
    // Level mode keeps requesting while low; edge mode fires once on the fall
    irq_event[`IRQ_ZERO_BIT] = port_c_function_config_ff[2] && !port_c_in_i[2] &&
      (!irq_zero_trigger_type || port_c_prev_ff[2]);
    irq_event[`IRQ_ONE_BIT] = port_c_function_config_ff[3] && !port_c_in_i[3] &&
      (!irq_one_trigger_type || port_c_prev_ff[3]);
  end

  // Sticky status; a read clears, but a new event in that cycle survives
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_ff <= `IRQ_RESET;
    end else begin
      irq_stat_ff <= (stat_rd ? 5'h00 : irq_stat_ff) | irq_event;
    end
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // Overflow strobe registered so the pin sees exactly one cycle per overflow
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer2_overflow_strobe_ff <= 1'b0;
    end else begin
      timer2_overflow_strobe_ff <= timer2_overflow_i;
    end
  end

  // Inputs to timers and UARTs; unselected pins present idle levels
  assign timer2_ext_input_o = port_b_function_config_ff[0] && timer2_counter_select_o &&
    port_b_in_i[0];
  assign timer2_capture_reload_input_o = port_b_function_config_ff[1] &&
    port_b_in_i[1];
  assign uart1_receive_input_o = port_b_function_config_ff[2] ? port_b_in_i[2] : 1'b1;
  assign uart0_receive_input_o = port_c_function_config_ff[0] ? port_c_in_i[0] : 1'b1;
  assign timer0_ext_input_o = port_c_function_config_ff[4] && timer0_counter_select_o &&
    port_c_in_i[4];
  assign timer1_ext_input_o = port_c_function_config_ff[5] && timer1_counter_select_o &&
    port_c_in_i[5];

  // Pad drivers: alternate outputs take over the pad, inputs release it
  always_comb begin
    port_b_out_o = gpio_b_out_ff;
    port_b_oe_o = gpio_b_oe_ff & ~port_b_function_config_ff;
    port_c_out_o = gpio_c_out_ff;
    port_c_oe_o = gpio_c_oe_ff & ~port_c_function_config_ff;
    if (port_b_function_config_ff[3]) begin
      port_b_out_o[3] = uart1_transmit_i;
      port_b_oe_o[3] = 1'b1;
    end
    if (port_b_function_config_ff[7]) begin
      port_b_out_o[7] = timer2_overflow_strobe_ff;
      port_b_oe_o[7] = 1'b1;
    end
    if (port_c_function_config_ff[1]) begin
      port_c_out_o[1] = uart0_transmit_i;
      port_c_oe_o[1] = 1'b1;
    end
  end

  // Read mux; unmapped indices read zero
  always_comb begin
    case (reg_addr_i)
      `PORT_B_CFG_ADDR: nxt_rdata = port_b_function_config_ff;
      `PORT_C_CFG_ADDR: nxt_rdata = {2'h0, port_c_function_config_ff};
      `PORT_B_OUT_ADDR: nxt_rdata = gpio_b_out_ff;
      `PORT_C_OUT_ADDR: nxt_rdata = {2'h0, gpio_c_out_ff};
      `PORT_B_OE_ADDR: nxt_rdata = gpio_b_oe_ff;
      `PORT_C_OE_ADDR: nxt_rdata = {2'h0, gpio_c_oe_ff};
      `PORT_B_PIN_ADDR: nxt_rdata = port_b_in_i;
      `PORT_C_PIN_ADDR: nxt_rdata = {2'h0, port_c_in_i};
      `TIMER_CTRL_ADDR: nxt_rdata = {3'h0, timer_ctrl_ff};
      `IRQ_STAT_ADDR: nxt_rdata = {3'h0, irq_stat_ff};
      `IRQ_MASK_ADDR: nxt_rdata = {3'h0, irq_mask_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata_o = reg_rdata_ff;

  // Checks beside the logic
  sequence s_rise4;
    port_b_function_config_ff[4] && port_b_in_i[4] && !port_b_prev_ff[4];
  endsequence
  sequence s_fall5;
    port_b_function_config_ff[5] && !port_b_in_i[5] && port_b_prev_ff[5];
  endsequence
  sequence s_rise6;
    port_b_function_config_ff[6] && port_b_in_i[6] && !port_b_prev_ff[6];
  endsequence
  sequence s_fall0_edge;
    port_c_function_config_ff[2] && irq_zero_trigger_type && port_c_prev_ff[2] &&
      !port_c_in_i[2];
  endsequence
  sequence s_fall1_edge;
    port_c_function_config_ff[3] && irq_one_trigger_type && port_c_prev_ff[3] &&
      !port_c_in_i[3];
  endsequence
  sequence s_low0_quiet;
    port_c_function_config_ff[2] && irq_zero_trigger_type && !port_c_prev_ff[2] &&
      !irq_stat_ff[`IRQ_ZERO_BIT];
  endsequence
  sequence s_low1_quiet;
    port_c_function_config_ff[3] && irq_one_trigger_type && !port_c_prev_ff[3] &&
      !irq_stat_ff[`IRQ_ONE_BIT];
  endsequence

  AST_T2_INPUT_GATED: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !timer2_counter_select_o |-> !timer2_ext_input_o)
    else $error("timer2 input passed while counter select clear");
  AST_T2_INPUT_ROUTE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_b_function_config_ff[0] && timer2_counter_select_o |->
      timer2_ext_input_o == port_b_in_i[0])
    else $error("timer2 input not routed from pin");
  AST_TIMER2_CAPTURE_RELOAD_INPUT_ROUTE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    timer2_capture_reload_input_o |-> port_b_function_config_ff[1] && port_b_in_i[1])
    else $error("capture input without select");
  AST_UART1_TX: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_b_function_config_ff[3] |-> port_b_oe_o[3] && port_b_out_o[3] == uart1_transmit_i)
    else $error("uart1 transmit not on pad");
  AST_IRQ4_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_rise4 |=> irq_stat_ff[`IRQ_FOUR_BIT])
    else $error("irq four not latched on rising edge");
  AST_IRQ5_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_fall5 |=> irq_stat_ff[`IRQ_FIVE_BIT])
    else $error("irq five not latched on falling edge");
  AST_TIMER2_OVERFLOW_STROBE_PULSE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_b_function_config_ff[7] && timer2_overflow_i && !$past(timer2_overflow_i) |=>
      port_b_out_o[7] ##1 !port_b_out_o[7] || !port_b_function_config_ff[7] ||
      $past(timer2_overflow_i))
    else $error("overflow strobe not one cycle");
  AST_UART0_TX: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_c_function_config_ff[1] |-> port_c_out_o[1] == uart0_transmit_i)
    else $error("uart0 transmit not on pad");
  AST_IRQ0_LEVEL: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_c_function_config_ff[2] && !irq_zero_trigger_type && !port_c_in_i[2] |=>
      irq_stat_ff[`IRQ_ZERO_BIT])
    else $error("irq zero level not latched");
  AST_T0_GATED: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    timer0_ext_input_o |-> timer0_counter_select_o && port_c_function_config_ff[4])
    else $error("timer0 input without select");

  // Receive and count inputs follow the pad only while their pin is given over
  AST_UART1_RX: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_b_function_config_ff[2] |-> uart1_receive_input_o == port_b_in_i[2])
    else $error("uart1 receive not taken from pin");
  AST_UART0_RX: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_c_function_config_ff[0] |-> uart0_receive_input_o == port_c_in_i[0])
    else $error("uart0 receive not taken from pin");
  AST_T2_IGNORED: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !port_b_function_config_ff[0] |-> !timer2_ext_input_o)
    else $error("timer2 input passed from a GPIO pin");
  AST_T0_INPUT_ROUTE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_c_function_config_ff[4] && timer0_counter_select_o |->
      timer0_ext_input_o == port_c_in_i[4])
    else $error("timer0 input not routed from pin");
  AST_T0_IGNORED: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !timer0_counter_select_o |-> !timer0_ext_input_o)
    else $error("timer0 input passed while counter select clear");
  AST_T1_GATED: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    timer1_ext_input_o |-> timer1_counter_select_o && port_c_function_config_ff[5])
    else $error("timer1 input without select");
  AST_T1_INPUT_ROUTE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_c_function_config_ff[5] && timer1_counter_select_o |->
      timer1_ext_input_o == port_c_in_i[5])
    else $error("timer1 input not routed from pin");

  // A pin given to an alternate input must never be driven, or it fights the board
  AST_B_ALT_IN_FREE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (port_b_oe_o & port_b_function_config_ff & `B_ALT_IN_MASK) == 8'h00)
    else $error("port B alternate input pin driven");
  AST_C_ALT_IN_FREE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (port_c_oe_o & port_c_function_config_ff & `C_ALT_IN_MASK) == 6'h00)
    else $error("port C alternate input pin driven");

  // Alternate outputs own their pad
  AST_UART0_TX_OE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_c_function_config_ff[1] |-> port_c_oe_o[1])
    else $error("uart0 transmit pad not driven");
  AST_TIMER2_OVERFLOW_STROBE_PAD: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_b_function_config_ff[7] |-> port_b_oe_o[7] &&
      port_b_out_o[7] == timer2_overflow_strobe_ff)
    else $error("overflow strobe not on pad");
  AST_TIMER2_OVERFLOW_STROBE_QUIET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !timer2_overflow_i |=> !timer2_overflow_strobe_ff)
    else $error("overflow strobe high without overflow");

  // Status bits: set on the right edge or level, and only from a selected pin
  AST_IRQ6_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_rise6 |=> irq_stat_ff[`IRQ_SIX_BIT])
    else $error("irq six not latched on rising edge");
  AST_IRQ0_EDGE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_fall0_edge |=> irq_stat_ff[`IRQ_ZERO_BIT])
    else $error("irq zero not latched on falling edge");
  AST_IRQ0_EDGE_ONCE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_low0_quiet |=> !irq_stat_ff[`IRQ_ZERO_BIT])
    else $error("irq zero re-raised by a held low in edge mode");
  AST_IRQ1_LEVEL: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    port_c_function_config_ff[3] && !irq_one_trigger_type && !port_c_in_i[3] |=>
      irq_stat_ff[`IRQ_ONE_BIT])
    else $error("irq one level not latched");
  AST_IRQ1_EDGE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_fall1_edge |=> irq_stat_ff[`IRQ_ONE_BIT])
    else $error("irq one not latched on falling edge");
  AST_IRQ1_EDGE_ONCE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_low1_quiet |=> !irq_stat_ff[`IRQ_ONE_BIT])
    else $error("irq one re-raised by a held low in edge mode");
  AST_IRQ4_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !port_b_function_config_ff[4] && !irq_stat_ff[`IRQ_FOUR_BIT] |=>
      !irq_stat_ff[`IRQ_FOUR_BIT])
    else $error("irq four raised from a GPIO pin");
  AST_IRQ5_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !port_b_function_config_ff[5] && !irq_stat_ff[`IRQ_FIVE_BIT] |=>
      !irq_stat_ff[`IRQ_FIVE_BIT])
    else $error("irq five raised from a GPIO pin");
  AST_IRQ6_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !port_b_function_config_ff[6] && !irq_stat_ff[`IRQ_SIX_BIT] |=>
      !irq_stat_ff[`IRQ_SIX_BIT])
    else $error("irq six raised from a GPIO pin");
  AST_IRQ0_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !port_c_function_config_ff[2] && !irq_stat_ff[`IRQ_ZERO_BIT] |=>
      !irq_stat_ff[`IRQ_ZERO_BIT])
    else $error("irq zero raised from a GPIO pin");
  AST_IRQ1_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !port_c_function_config_ff[3] && !irq_stat_ff[`IRQ_ONE_BIT] |=>
      !irq_stat_ff[`IRQ_ONE_BIT])
    else $error("irq one raised from a GPIO pin");
  AST_STAT_STICKY: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    irq_stat_ff[`IRQ_FOUR_BIT] && !stat_rd |=> irq_stat_ff[`IRQ_FOUR_BIT])
    else $error("irq four status lost without a read");

  // First edge out of reset: every pin a GPIO input
  AST_CFG_RESET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !$past(rst_b_i) |-> port_b_function_config_ff == `CFG_B_RESET &&
      port_c_function_config_ff == `CFG_C_RESET && port_b_oe_o == 8'h00 &&
      port_c_oe_o == 6'h00)
    else $error("select bits or drives not clear after reset");
endmodule

// [verification/board_model.sv]
`timescale 1ns/1ps
// Board side of the pads: each line sits at the board level unless the chip drives it
module board_model (
  input wire logic [7:0] b_lvl_i, // Board level, port B
  input wire logic [5:0] c_lvl_i, // Board level, port C
  input wire logic [7:0] b_oe_i, // Chip drive enable, B
  input wire logic [7:0] b_out_i, // Chip drive value, B
  input wire logic [5:0] c_oe_i, // Chip drive enable, C
  input wire logic [5:0] c_out_i, // Chip drive value, C
  output logic [7:0] b_pad_o, // Wire level, B
  output logic [5:0] c_pad_o // Wire level, C
);
  // Chip wins; board drivers sit behind series resistors
  assign b_pad_o = (b_oe_i & b_out_i) | (~b_oe_i & b_lvl_i);
  assign c_pad_o = (c_oe_i & c_out_i) | (~c_oe_i & c_lvl_i);
endmodule

// [verification/port_b_c_alternate_function_mux_test.sv]
`timescale 1ns/1ps
module port_b_c_alternate_function_mux_test;
  import pin_mux_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  reg_addr_type reg_addr_i = 4'h0;
  reg_data_type reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  reg_data_type reg_rdata_o;
  logic [7:0] port_b_in_i, port_b_out_o, port_b_oe_o, cb, ob, vb, eo;
  logic [5:0] port_c_in_i, port_c_out_o, port_c_oe_o, cc, oc, vc, ec;
  logic [7:0] b_lvl = 8'h00;
  logic [5:0] c_lvl = 6'h00;
  logic timer2_overflow_i = 1'b0;
  logic uart1_transmit_i = 1'b0;
  logic uart0_transmit_i = 1'b0;
  logic timer0_ext_input_o, timer1_ext_input_o, timer2_ext_input_o, irq_o;
  logic timer2_capture_reload_input_o, uart1_receive_input_o, uart0_receive_input_o;
  logic timer0_counter_select_o, timer1_counter_select_o, timer2_counter_select_o;
  logic [4:0] t;
  logic [13:0] f;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  port_b_c_alternate_function_mux u_dut (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .port_b_in_i, .port_b_out_o, .port_b_oe_o,
    .port_c_in_i, .port_c_out_o, .port_c_oe_o, .timer2_overflow_i, .uart1_transmit_i,
    .uart0_transmit_i, .timer0_ext_input_o, .timer1_ext_input_o, .timer2_ext_input_o,
    .timer2_capture_reload_input_o, .uart1_receive_input_o, .uart0_receive_input_o,
    .timer0_counter_select_o, .timer1_counter_select_o, .timer2_counter_select_o, .irq_o);
  board_model u_board (.b_lvl_i(b_lvl), .c_lvl_i(c_lvl), .b_oe_i(port_b_oe_o),
    .b_out_i(port_b_out_o), .c_oe_i(port_c_oe_o), .c_out_i(port_c_out_o),
    .b_pad_o(port_b_in_i), .c_pad_o(port_c_in_i));

  // 100 MHz core clock
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard, well above the roughly 750 cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask

  task automatic pins(input logic [13:0] v);
    @(posedge clk_sys_i);
    {c_lvl, b_lvl} <= v;
  endtask

  // Expected pad levels: chip-driven lines show the chip, the rest the board
  function automatic logic [7:0] pad_b(input logic [7:0] c, o, v);
    pad_b = ((v ^ (o & ~c)) & ~(c & 8'h88)) | {4'h0, c[3] & v[7], 3'h0};
  endfunction

  function automatic logic [5:0] pad_c(input logic [5:0] c, o, v);
    pad_c = ((v ^ (o & ~c)) & ~(c & 6'h02)) | {4'h0, c[1] & v[3], 1'b0};
  endfunction

  // Main sequence
  initial begin
    void'($urandom(82));
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    #1 chk(port_b_oe_o, 8'h00);
    chk(port_c_oe_o, 6'h00);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    // Idle levels first so selecting the pins makes no edge
    pins(14'h0c20);
    wr(4'h0, 8'h70);
    wr(4'h1, 8'h0c);
    wr(4'h8, 8'h18);
    wr(4'ha, 8'h1f);
    rd(4'h9, 8'h00);
    for (int i = 0; i < 5; i++) begin
      f = (i < 3) ? 14'h0010 << i : 14'h0400 << (i - 3);
      wr(4'ha, (i == 2) ? 8'h1b : 8'h1f);
      pins({c_lvl, b_lvl} ^ f);
      repeat (3) @(posedge clk_sys_i);
      #1 chk(irq_o, i != 2);
      rd(4'h9, 8'h01 << i);
      @(posedge clk_sys_i);
      #1 chk(irq_o, 1'b0);
      pins({c_lvl, b_lvl} ^ f);
      repeat (3) @(posedge clk_sys_i);
      rd(4'h9, 8'h00);
    end
    // Level mode keeps re-raising while the line stays low
    wr(4'h8, 8'h00);
    for (int j = 0; j < 2; j++) begin
      pins({c_lvl, b_lvl} ^ (14'h0400 << j));
      repeat (3) @(posedge clk_sys_i);
      rd(4'h9, 8'h08 << j);
      rd(4'h9, 8'h08 << j);
      pins({c_lvl, b_lvl} ^ (14'h0400 << j));
      repeat (3) @(posedge clk_sys_i);
      rd(4'h9, 8'h08 << j);
      rd(4'h9, 8'h00);
    end
    // Overflow strobe on the last B line
    wr(4'h0, 8'h80);
    @(posedge clk_sys_i);
    timer2_overflow_i <= 1'b1;
    @(posedge clk_sys_i);
    timer2_overflow_i <= 1'b0;
    #1 chk(port_b_out_o[7], 1'b1);
    @(posedge clk_sys_i);
    #1 chk(port_b_out_o[7], 1'b0);
    // Random selections, drive settings and board levels
    repeat (24) begin
      cb = 8'($urandom);
      cc = 6'($urandom);
      t = 5'($urandom) & 5'h07;
      ob = 8'($urandom);
      oc = 6'($urandom);
      vb = 8'($urandom);
      vc = 6'($urandom);
      wr(4'h0, cb);
      wr(4'h1, {2'b0, cc});
      wr(4'h2, ~vb);
      wr(4'h3, {2'b0, ~vc});
      wr(4'h4, ob);
      wr(4'h5, {2'b0, oc});
      wr(4'h8, {3'b0, t});
      pins({vc, vb});
      uart1_transmit_i <= vb[7];
      uart0_transmit_i <= vc[3];
      repeat (2) @(posedge clk_sys_i);
      #1 chk(timer2_ext_input_o, vb[0] & cb[0] & t[2]);
      chk(timer2_capture_reload_input_o, vb[1] & cb[1]);
      chk(uart1_receive_input_o, cb[2] ? vb[2] : 1'b1);
      chk(uart0_receive_input_o, cc[0] ? vc[0] : 1'b1);
      chk(timer0_ext_input_o, vc[4] & cc[4] & t[0]);
      chk(timer1_ext_input_o, vc[5] & cc[5] & t[1]);
      chk({timer2_counter_select_o, timer1_counter_select_o, timer0_counter_select_o},
        t[2:0]);
      eo = (ob & ~cb) | (cb & 8'h88);
      ec = (oc & ~cc) | (cc & 6'h02);
      chk(port_b_oe_o, eo);
      chk(port_c_oe_o, ec);
      chk(port_b_out_o & eo, eo & ((~vb & ~cb) | {4'h0, cb[3] & vb[7], 3'h0}));
      chk(port_c_out_o & ec, ec & ((~vc & ~cc) | {4'h0, cc[1] & vc[3], 1'b0}));
      rd(4'h6, pad_b(cb, ob, vb));
      rd(4'h7, {2'h0, pad_c(cc, oc, vc)});
      rd(4'h0, cb);
      rd(4'h8, {3'h0, t});
    end
    summarize();
  end
endmodule
